// [shared/sbrc_pkg.sv]
/*
  Package for the SDRAM bank, refresh and read control block: command
  encodings, timing constants, state enumerations.
  Assumes a single 125 MHz clock domain.
*/
package sbrc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS   = 4;
  localparam int ROW_W       = 12;
  localparam int COL_W       = 9;
  localparam int DQ_W        = 16;
  localparam int AP_BIT      = 10;
  localparam int REFRESH_ROWS = 4096;

  // ----------------------------------------------------------------
  // Commands as {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_ACT    = 4'h3;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam logic [3:0] CMD_BST    = 4'h6;
  localparam logic [3:0] CMD_PRE    = 4'h2;
  localparam logic [3:0] CMD_REF    = 4'h1;
  localparam logic [3:0] CMD_LMR    = 4'h0;

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [2:0] CL_RESET     = 3'h3;
  localparam logic [2:0] BL_RESET     = 3'h2;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 8000;
  localparam int ROW_PRECHARGE_PS     = 24000;
  localparam int MIN_ROW_ACTIVE_PS    = 48000;
  localparam int REFRESH_CYCLE_PS     = 80000;
  localparam int SELF_REF_INTERVAL_NS = 15625;
  localparam int ROW_PRECHARGE_CYC    = (ROW_PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_ROW_ACTIVE_CYC   = (MIN_ROW_ACTIVE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYCLE_CYC    = (REFRESH_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SELF_REF_INTERVAL_CYC = (SELF_REF_INTERVAL_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SBRC_NORMAL   = 2'b00,
    SBRC_SELF_REF = 2'b01,
    SBRC_DEEP_PD  = 2'b10
  } sbrc_pwr_e;

endpackage

// [shared/sbrc_bank_if.sv]
/*
  Carrier between the command decoder and the bank tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface sbrc_bank_if;
  import sbrc_pkg::*;
  logic                 act_pulse;
  logic                 pre_pulse;
  logic                 pre_all;
  logic [1:0]           bank;
  logic [ROW_W-1:0]     row;
  logic                 clear_all;
  logic [NUM_BANKS-1:0] open;
  logic [NUM_BANKS*ROW_W-1:0] open_row;

  modport ctrl (output act_pulse, pre_pulse, pre_all, bank, row, clear_all, input open, open_row);
  modport bank_side (input act_pulse, pre_pulse, pre_all, bank, row, clear_all, output open, open_row);
endinterface

// [verilog/sbrc_bank_track.sv]
/*
  Per-bank open/idle tracker with the open row per bank.
  Assumes pulses come from the decoder on the same clock.
*/
`timescale 1ns/10ps
module sbrc_bank_track (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Decoder side
  sbrc_bank_if.bank_side bif
);
  import sbrc_pkg::*;

  logic [NUM_BANKS-1:0]       open_q,  open_d;
  logic [NUM_BANKS*ROW_W-1:0] row_q,   row_d;

  // --------------------------------------------------------------
  // Per-bank state
  // --------------------------------------------------------------
  always_comb begin
    open_d = open_q;
    row_d  = row_q;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bif.clear_all || (bif.pre_pulse && (bif.pre_all || bif.bank == 2'(b)))) begin
        open_d[b] = 1'b0;
      end else if (bif.act_pulse && bif.bank == 2'(b)) begin
        open_d[b] = 1'b1;
        row_d[b*ROW_W +: ROW_W] = bif.row;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      open_q <= '0;
      row_q  <= '0;
    end else begin
      open_q <= open_d;
      row_q  <= row_d;
    end
  end

  assign bif.open     = open_q;
  assign bif.open_row = row_q;
endmodule

// [verilog/sbrc_core.sv]
/*
  Command decoder, bank tracking, refresh and read-burst sequencing of a
  four-bank synchronous DRAM, seen from inside the device.
  Assumes the controller drives pins synchronously to mclk and keeps its
  own timing obligations; array data comes in one cycle after the column.
*/
// Operation
// - A10 high precharges bank after burst
// - No auto precharge in full page mode
// - Auto precharge chosen per command only
// - Burst terminate stops latest read/write
// - Refresh row from internal counter
// - Self refresh: refresh with clock enable low
// - Self refresh runs own internal refresh
// - Deep power-down on terminate, enable low
// - Clock enable high leaves deep power-down
// - Read data after CAS latency, then float
// - Full page wraps to column zero
// - New read truncates with no gap
// - Reads accepted every clock
`timescale 1ns/10ps
module sbrc_core (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [1:0]                 ba,
  input  wire logic [sbrc_pkg::ROW_W-1:0] addr,
  input  wire logic [1:0]                 dqm,
  // Data pins
  output logic      [sbrc_pkg::DQ_W-1:0]  dq_o,
  output logic      [sbrc_pkg::DQ_W-1:0]  dq_oe,
  // Array port
  output logic                            arr_rd,
  output logic                            arr_ref,
  output logic      [1:0]                 arr_bank,
  output logic      [sbrc_pkg::ROW_W-1:0] arr_row,
  output logic      [sbrc_pkg::COL_W-1:0] arr_col,
  input  wire logic [sbrc_pkg::DQ_W-1:0]  arr_rdata,
  // Status
  output logic                            self_ref_active,
  output logic                            deep_pd_active,
  output logic                            access_error
);
  import sbrc_pkg::*;

  sbrc_bank_if bif ();

  sbrc_bank_track u_track (
    .mclk (mclk),
    .rstn (rstn),
    .bif  (bif)
  );

  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  logic [3:0] cmd;
  logic       awake;
  logic       is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_lmr;
  logic       is_self, is_dpd;
  sbrc_pwr_e  pwr_q, pwr_d;

  assign cmd    = {cs_n, ras_n, cas_n, we_n};
  assign awake  = (pwr_q == SBRC_NORMAL);
  assign is_act = awake && cke && cmd == CMD_ACT;
  assign is_rd  = awake && cke && cmd == CMD_READ;
  assign is_wr  = awake && cke && cmd == CMD_WRITE;
  assign is_bst = awake && cke && cmd == CMD_BST;
  assign is_pre = awake && cke && cmd == CMD_PRE;
  assign is_ref = awake && cke && cmd == CMD_REF;
  assign is_lmr = awake && cke && cmd == CMD_LMR;
  assign is_self = awake && !cke && cmd == CMD_REF;
  // terminate code, enable low, banks idle
  assign is_dpd  = awake && !cke && cmd == CMD_BST && bif.open == '0;

  // --------------------------------------------------------------
  // Mode register
  // --------------------------------------------------------------
  logic [2:0] bl_q, bl_d, cl_q, cl_d;
  logic       full_page;

  always_comb begin
    bl_d = bl_q;
    cl_d = cl_q;
    if (is_lmr && ba == 2'b00) begin
      bl_d = addr[MODE_BL_LSB +: 3];
      cl_d = addr[MODE_CL_LSB +: 3];
    end
  end
  assign full_page = (bl_q == BL_FULL_PAGE);

  // --------------------------------------------------------------
  // Power states and internal refresh
  // --------------------------------------------------------------
  logic [ROW_W-1:0] ref_row_q, ref_row_d;
  logic [10:0]      sr_tmr_q, sr_tmr_d;
  logic             int_ref;

  always_comb begin
    pwr_d    = pwr_q;
    sr_tmr_d = sr_tmr_q;
    int_ref  = 1'b0;
    unique case (pwr_q)
      SBRC_NORMAL: begin
        sr_tmr_d = '0;
        if (is_self) begin
          pwr_d = SBRC_SELF_REF;
        end else if (is_dpd) begin
          pwr_d = SBRC_DEEP_PD;
        end
      end
      SBRC_SELF_REF: begin
        if (sr_tmr_q == 11'(SELF_REF_INTERVAL_CYC - 1)) begin
          sr_tmr_d = '0;
          int_ref  = 1'b1;
        end else begin
          sr_tmr_d = sr_tmr_q + 11'h1;
        end
        if (cke) begin
          pwr_d = SBRC_NORMAL;
        end
      end
      SBRC_DEEP_PD: begin
        if (cke) begin
          pwr_d = SBRC_NORMAL;
        end
      end
      default: pwr_d = SBRC_NORMAL;
    endcase
  end

  assign ref_row_d = (is_ref || int_ref) ? ref_row_q + 12'h1 : ref_row_q;

  // --------------------------------------------------------------
  // Burst sequencer
  // --------------------------------------------------------------
  logic             bact_q, bact_d;
  logic             bwr_q, bwr_d;
  logic             ap_q, ap_d;
  logic [1:0]       bbank_q, bbank_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [8:0]       left_q, left_d;
  logic             acc_ok, ap_fire;
  logic [8:0]       blen;

  always_comb begin
    unique case (bl_q)
      3'h0:    blen = 9'h1;
      3'h1:    blen = 9'h2;
      3'h2:    blen = 9'h4;
      3'h3:    blen = 9'h8;
      default: blen = 9'h1;
    endcase
  end

  assign acc_ok = bif.open[ba];

  always_comb begin
    bact_d  = bact_q;
    bwr_d   = bwr_q;
    ap_d    = ap_q;
    bbank_d = bbank_q;
    col_d   = col_q;
    left_d  = left_q;
    ap_fire = 1'b0;
    if (bact_q) begin
      col_d = col_q + 9'h1;
      if (!full_page) begin
        left_d = left_q - 9'h1;
        if (left_q == 9'h1) begin
          bact_d = 1'b0;
          ap_fire = ap_q;
        end
      end
    end
    if (is_bst) begin
      bact_d = 1'b0;
    end
    if ((is_rd || is_wr) && acc_ok) begin
      bact_d  = !(full_page == 1'b0 && blen == 9'h1);
      bwr_d   = is_wr;
      bbank_d = ba;
      col_d   = addr[COL_W-1:0] + 9'h1;
      left_d  = blen - 9'h1;
      ap_d    = addr[AP_BIT] && !full_page;
    end
  end

  // Single-beat auto precharge resolved one cycle later
  logic       ap1_q, ap1_d;
  logic [1:0] ap1_bank_q, ap1_bank_d;
  assign ap1_d      = (is_rd || is_wr) && acc_ok && addr[AP_BIT] && !full_page && blen == 9'h1;
  assign ap1_bank_d = ba;

  assign bif.act_pulse = is_act;
  assign bif.bank      = (ap_fire && !is_pre) ? bbank_q : (ap1_q ? ap1_bank_q : ba);
  assign bif.row       = addr;
  assign bif.pre_pulse = is_pre || ap_fire || ap1_q;
  assign bif.pre_all   = is_pre && addr[AP_BIT];
  assign bif.clear_all = (pwr_q == SBRC_DEEP_PD);

  // --------------------------------------------------------------
  // Read data pipeline
  // --------------------------------------------------------------
  logic [7:0]       rv_q, rv_d;
  logic [1:0]       dqm1_q;
  logic [DQ_W-1:0]  rd1_q;
  logic             rd_beat;
  logic [DQ_W-1:0]  dq_q, dq_d;
  logic [DQ_W-1:0]  oe_q, oe_d;
  logic [2:0]       cl_idx;

  assign rd_beat = (is_rd && acc_ok) || (bact_q && !bwr_q && !(is_bst || is_wr || is_rd));
  assign rv_d    = {rv_q[6:0], rd_beat};
  assign cl_idx  = (cl_q == 3'h2) ? 3'h1 : 3'h2;

  // data after CAS latency, then high-z
  always_comb begin
    dq_d = dq_q;
    oe_d = '0;
    if (rv_q[cl_idx - 3'h1] && !is_wr) begin
      // Latency three takes the word one cycle older
      dq_d = (cl_idx == 3'h1) ? arr_rdata : rd1_q;
      for (int i = 0; i < 2; i++) begin
        oe_d[i*8 +: 8] = {8{!dqm1_q[i]}};
      end
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_q      <= SBRC_NORMAL;
      sr_tmr_q   <= '0;
      ref_row_q  <= '0;
      bl_q       <= BL_RESET;
      cl_q       <= CL_RESET;
      bact_q     <= 1'b0;
      bwr_q      <= 1'b0;
      ap_q       <= 1'b0;
      bbank_q    <= '0;
      col_q      <= '0;
      left_q     <= '0;
      ap1_q      <= 1'b0;
      ap1_bank_q <= '0;
      rv_q       <= '0;
      dqm1_q     <= '0;
      rd1_q      <= '0;
      dq_q       <= '0;
      oe_q       <= '0;
    end else begin
      pwr_q      <= pwr_d;
      sr_tmr_q   <= sr_tmr_d;
      ref_row_q  <= ref_row_d;
      bl_q       <= bl_d;
      cl_q       <= cl_d;
      bact_q     <= bact_d;
      bwr_q      <= bwr_d;
      ap_q       <= ap_d;
      bbank_q    <= bbank_d;
      col_q      <= col_d;
      left_q     <= left_d;
      ap1_q      <= ap1_d;
      ap1_bank_q <= ap1_bank_d;
      rv_q       <= rv_d;
      dqm1_q     <= dqm;
      rd1_q      <= arr_rdata;
      dq_q       <= dq_d;
      oe_q       <= oe_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign dq_o            = dq_q;
  assign dq_oe           = oe_q;
  assign arr_rd          = rd_beat;
  assign arr_ref         = is_ref || int_ref;
  assign arr_bank        = (is_rd && acc_ok) ? ba : bbank_q;
  assign arr_col         = (is_rd && acc_ok) ? addr[COL_W-1:0] : col_q;
  assign arr_row         = (is_ref || int_ref) ? ref_row_q : bif.open_row[arr_bank*ROW_W +: ROW_W];
  assign self_ref_active = (pwr_q == SBRC_SELF_REF);
  assign deep_pd_active  = (pwr_q == SBRC_DEEP_PD);
  assign access_error    = (is_rd || is_wr) && !acc_ok;
endmodule

// [tb/sbrc_core_sva.sv]
/*
  Checker on the ports of sbrc_core.
  Assumes only the ports of sbrc_core are visible to it.
*/
`timescale 1ns/10ps
module sbrc_core_sva
  import sbrc_pkg::*;
(
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       rstn,
  // Command pins
  input wire logic                       cke,
  input wire logic                       cs_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  input wire logic [1:0]                 ba,
  input wire logic [sbrc_pkg::ROW_W-1:0] addr,
  input wire logic [1:0]                 dqm,
  // Data, array and status
  input wire logic [sbrc_pkg::DQ_W-1:0]  dq_o,
  input wire logic [sbrc_pkg::DQ_W-1:0]  dq_oe,
  input wire logic                       arr_rd,
  input wire logic                       arr_ref,
  input wire logic [1:0]                 arr_bank,
  input wire logic [sbrc_pkg::ROW_W-1:0] arr_row,
  input wire logic [sbrc_pkg::COL_W-1:0] arr_col,
  input wire logic [sbrc_pkg::DQ_W-1:0]  arr_rdata,
  input wire logic                       self_ref_active,
  input wire logic                       deep_pd_active,
  input wire logic                       access_error
);
  logic [3:0]       cmd;
  logic             go;
  logic             cl2_q;
  logic             lv_q;
  logic [ROW_W-1:0] last_q;
  logic [11:0]      sr_q;

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign go  = cke && !self_ref_active && !deep_pd_active;

  // ----------------------------------------
  // Mode, refresh row and interval trackers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cl2_q  <= 1'b0;
      lv_q   <= 1'b0;
      last_q <= '0;
      sr_q   <= 12'h0;
    end else begin
      if (go && cmd == CMD_LMR && ba == 2'h0)
        cl2_q <= addr[6:4] == 3'h2;
      if (arr_ref) begin
        lv_q   <= 1'b1;
        last_q <= arr_row;
      end
      sr_q <= (self_ref_active && !arr_ref) ? sr_q + 12'h1 : 12'h0;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    go && cmd == CMD_READ && !access_error && dqm == 2'h0;
  endsequence
  sequence s_bst;
    go && cmd == CMD_BST;
  endsequence
  sequence s_sref_cmd;
    !cke && !self_ref_active && !deep_pd_active && cmd == CMD_REF;
  endsequence

  a_rd_lat_two: assert property (s_rd ##0 cl2_q |-> ##2 dq_oe == 16'hffff)
    else $error("first read word missing at latency two");
  a_rd_lat_three: assert property (s_rd ##0 !cl2_q ##1 dqm == 2'h0 |-> ##2 dq_oe == 16'hffff)
    else $error("first read word missing at latency three");
  a_bst_stop: assert property (s_bst ##0 !cl2_q |-> ##3 dq_oe == '0)
    else $error("burst still driving after terminate");
  a_ref_now: assert property (go && cmd == CMD_REF |-> arr_ref)
    else $error("auto refresh without array refresh");
  a_ref_row_step: assert property (arr_ref && lv_q |-> arr_row == last_q + 12'h1)
    else $error("refresh row not from counter");
  a_sref_enter: assert property (s_sref_cmd |=> self_ref_active)
    else $error("self refresh not entered");
  a_sref_quiet: assert property (self_ref_active && $past(self_ref_active) |-> !arr_rd && !access_error)
    else $error("command acted on in self refresh");
  a_sref_exit: assert property (self_ref_active && cke |=> !self_ref_active)
    else $error("self refresh kept after clock enable");
  a_sref_tick: assert property (sr_q <= SELF_REF_INTERVAL_CYC + 4)
    else $error("no internal refresh in self refresh");
  a_dpd_exit: assert property (deep_pd_active && cke |=> !deep_pd_active)
    else $error("deep power-down kept after clock enable");
endmodule

bind sbrc_core sbrc_core_sva u_sva (.*);

// [tb/sbrc_ctl_model.sv]
/*
  Controller model driving command, bank and address pins.
  Assumes its tasks are entered at a falling edge of mclk.
*/
`timescale 1ns/10ps
module sbrc_ctl_model
  import sbrc_pkg::*;
(
  // Clock
  input  wire logic                  mclk,
  // Command pins
  output logic                       cke,
  output logic [3:0]                 cmd,
  output logic [1:0]                 ba,
  output logic [sbrc_pkg::ROW_W-1:0] addr
);
  initial begin
    cke  = 1'b1;
    cmd  = CMD_NOP;
    ba   = 2'h0;
    addr = '0;
  end

  // ----------------------------------------
  // Command tasks
  // ----------------------------------------
  // No write data ever driven
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [ROW_W-1:0] a, input logic k);
    cke  = k;
    cmd  = c;
    ba   = b;
    addr = a;
    @(negedge mclk);
  endtask

  // Idle lines toggle so stale values never pass
  task automatic nop(input int n);
    repeat (n) begin
      cmd  = CMD_NOP;
      ba   = ~ba;
      addr = ~addr;
      @(negedge mclk);
    end
  endtask

  task automatic act(input logic [1:0] b, input logic [ROW_W-1:0] r);
    issue(CMD_ACT, b, r, 1'b1);
    nop(2);
  endtask

  task automatic prea();
    issue(CMD_PRE, 2'h0, 12'h400, 1'b1);
    nop(ROW_PRECHARGE_CYC);
  endtask
endmodule

// [tb/tb_sdram_bank_refresh_read_control.sv]
/*
  Bench for sbrc_core: controller model, array stub, read stream model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
module tb_sdram_bank_refresh_read_control;
  import sbrc_pkg::*;
  typedef struct {int s; int e; int b; int c;} sbrc_burst_s;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  logic             err_q = 1'b0;
  logic             cke, arr_rd, arr_ref, self_ref_active, deep_pd_active, access_error;
  logic [3:0]       cmd;
  logic [1:0]       ba, arr_bank;
  logic [ROW_W-1:0] addr, arr_row;
  logic [COL_W-1:0] arr_col;
  logic [DQ_W-1:0]  dq_o, dq_oe, arr_rdata;
  logic [1:0]       dqm = 2'h0, dqm_p1 = 2'h0, dqm_p2 = 2'h0;
  logic [ROW_W-1:0] open_row [4];
  bit               open_b [4];
  logic [ROW_W-1:0] refs [$];
  sbrc_burst_s      bq [$];
  int               err_total = 0;
  int               samples_checked = 0;
  int               cyc = 0;
  int               cl = 3;
  int               bl = 4;

  always #4 mclk = ~mclk;
  // Array stub answers one cycle after the column; mask history for the model
  always @(posedge mclk) begin
    arr_rdata <= {arr_bank, arr_row[4:0], arr_col};
    dqm_p1 <= dqm;
    dqm_p2 <= dqm_p1;
    cyc <= cyc + 1;
    err_q <= access_error;
    if (arr_ref) refs.push_back(arr_row);
  end

  sbrc_core DUT (.mclk(mclk), .rstn(rstn), .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
    .we_n(cmd[0]), .ba(ba), .addr(addr), .dqm(dqm), .dq_o(dq_o), .dq_oe(dq_oe), .arr_rd(arr_rd),
    .arr_ref(arr_ref), .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col), .arr_rdata(arr_rdata),
    .self_ref_active(self_ref_active), .deep_pd_active(deep_pd_active), .access_error(access_error));
  sbrc_ctl_model ctl (.mclk(mclk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr));

  // Occasional random byte masks on reads
  always @(negedge mclk) dqm = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;

  // ----------------------------------------
  // Compare, model and command helpers
  // ----------------------------------------
  task automatic chk_w(input logic [DQ_W-1:0] e, input logic [DQ_W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_b(input logic e, input logic g);
    chk_w({15'h0, e}, {15'h0, g});
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [DQ_W-1:0] word(input int b, input int c);
    return {b[1:0], open_row[b][4:0], c[8:0]};
  endfunction
  task automatic trunc(input int s);
    foreach (bq[i]) if (bq[i].e > s) bq[i].e = s;
  endtask
  task automatic rd(input int b, input int c, input bit ap);
    int s;
    s = cyc + cl;
    if (open_b[b]) begin
      trunc(s);
      bq.push_back('{s, s + bl, b, c});
    end
    ctl.issue(CMD_READ, b[1:0], {1'b0, ap, 1'b0, c[8:0]}, 1'b1);
    chk_b(!open_b[b], err_q);
    if (ap && bl < 512) open_b[b] = 1'b0;
  endtask
  task automatic act(input int b);
    open_row[b] = ROW_W'($urandom);
    open_b[b] = 1'b1;
    ctl.act(b[1:0], open_row[b]);
  endtask
  task automatic lmr(input int cl_v, input int blc);
    cl = cl_v;
    bl = (blc == 7) ? 1 << 20 : 1 << blc;
    ctl.issue(CMD_LMR, 2'h0, {5'h0, cl_v[2:0], 1'b0, blc[2:0]}, 1'b1);
    ctl.nop(2);
  endtask

  // Expected read stream against the data pins
  always @(negedge mclk) begin
    while (bq.size() > 0 && bq[0].e <= cyc) void'(bq.pop_front());
    if (bq.size() > 0 && bq[0].s <= cyc) begin
      chk_w(word(bq[0].b, bq[0].c + cyc - bq[0].s), dq_o);
      chk_w({{8{!dqm_p2[1]}}, {8{!dqm_p2[0]}}}, dq_oe);
    end else
      chk_w(16'h0, dq_oe);
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    int i;
    void'($urandom(10093));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk_b(1'b0, self_ref_active);
    chk_b(1'b0, deep_pd_active);
    $display("test reset done");
    act(0);
    act(1);
    rd(0, 4 * ($urandom % 128), 0);
    ctl.nop(1);
    rd(1, 16, 0);
    rd(0, 4, 0);
    rd(0, 12, 0);
    rd(1, 0, 0);
    ctl.nop(12);
    $display("test reads done");
    lmr(2, 3);
    rd(0, 32, 1);
    ctl.nop(12);
    rd(0, 40, 0);
    rd(1, 8, 0);
    rd(1, 16, 0);
    ctl.nop(12);
    $display("test auto precharge done");
    lmr(3, 7);
    rd(1, 510, 1);
    ctl.nop(5);
    trunc(cyc + cl);
    ctl.issue(CMD_BST, 2'($urandom), ROW_W'($urandom), 1'b1);
    ctl.nop(6);
    rd(1, 100, 0);
    trunc(cyc + cl);
    ctl.issue(CMD_BST, 2'($urandom), ROW_W'($urandom), 1'b1);
    ctl.nop(8);
    lmr(3, 2);
    $display("test full page done");
    ctl.prea();
    open_b = '{default: 1'b0};
    n = refs.size();
    repeat (2) begin
      ctl.issue(CMD_REF, 2'($urandom), ROW_W'($urandom), 1'b1);
      ctl.nop(REFRESH_CYCLE_CYC);
    end
    chk_w({4'h0, refs[n] + 12'h1}, {4'h0, refs[n+1]});
    $display("test refresh done");
    ctl.issue(CMD_REF, 2'($urandom), ROW_W'($urandom), 1'b0);
    n = refs.size();
    chk_b(1'b1, self_ref_active);
    ctl.issue(CMD_READ, 2'h1, ROW_W'($urandom), 1'b0);
    chk_b(1'b0, err_q);
    for (i = 0; i < 2100 && refs.size() == n; i++) ctl.nop(1);
    if (refs.size() == n) begin
      err_total++;
      tally_and_finish();
    end
    chk_w({4'h0, refs[n-1] + 12'h1}, {4'h0, refs[n]});
    ctl.issue(CMD_NOP, 2'($urandom), ROW_W'($urandom), 1'b1);
    ctl.nop(2);
    chk_b(1'b0, self_ref_active);
    ctl.issue(CMD_REF, 2'($urandom), ROW_W'($urandom), 1'b1);
    ctl.nop(REFRESH_CYCLE_CYC);
    $display("test self refresh done");
    ctl.issue(CMD_BST, 2'($urandom), ROW_W'($urandom), 1'b0);
    ctl.nop(3);
    chk_b(1'b1, deep_pd_active);
    ctl.issue(CMD_NOP, 2'($urandom), ROW_W'($urandom), 1'b1);
    ctl.nop(1);
    chk_b(1'b0, deep_pd_active);
    $display("test deep power-down done");
    tally_and_finish();
  end
endmodule
